// ==== hdl/cbod_unit.sv ====
// Function
// - ordered less-or-equal compare writes 1 only if no NaN and s <= t.
// - ordered less-than compare writes 1 only if no NaN and s < t.
// - plus zero and minus zero compare equal in both compares.
// - any NaN operand forces compare result to 0.
// - fp unit disabled makes compares raise exception, no Boolean write.
// - bitwise OR of two address registers into destination address register.
// - Boolean OR of two Boolean bits into destination Boolean bit.
// - Boolean OR of first bit with complement of second bit.
// - signed 32-bit quotient truncated toward zero into address register.
// - signed quotient by zero raises divide exception, no write.
// - most negative by minus one gives no exception or overflow flag.
// - unsigned 32-bit quotient low bits into address register.
// - unsigned quotient by zero raises divide exception, no write.
`timescale 1ns/1ps
`default_nettype none
`include "cbod_consts.svh"
module cbod_unit
  import cbod_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        ISSUE_VALID,
  input  wire logic [23:0] INSTR,
  input  wire logic        FP_ENABLE,
  output logic             ISSUE_READY,
  output logic [3:0]       AR_RADDR_S,
  output logic [3:0]       AR_RADDR_T,
  input  wire logic [31:0] AR_RDATA_S,
  input  wire logic [31:0] AR_RDATA_T,
  output logic [3:0]       FR_RADDR_S,
  output logic [3:0]       FR_RADDR_T,
  input  wire logic [31:0] FR_RDATA_S,
  input  wire logic [31:0] FR_RDATA_T,
  output logic [3:0]       BR_RADDR_S,
  output logic [3:0]       BR_RADDR_T,
  input  wire logic        BR_RDATA_S,
  input  wire logic        BR_RDATA_T,
  output logic             AR_WE,
  output logic [3:0]       AR_WADDR,
  output logic [31:0]      AR_WDATA,
  output logic             BR_WE,
  output logic [3:0]       BR_WADDR,
  output logic             BR_WDATA,
  output logic             FP_UNIT_DISABLED_EXC,
  output logic             DIVIDE_BY_ZERO_EXC
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_nan(input logic [31:0] f);
    is_nan = (f[30:23] == 8'hff) && (f[22:0] != 23'h000000);
  endfunction : is_nan

  // numeric order key: zeros of either sign map to the same key
  function automatic logic [31:0] ord_key(input logic [31:0] f);
    if (f[30:0] == 31'h00000000)
      ord_key = 32'h80000000;
    else if (f[31])
      ord_key = ~f;
    else
      ord_key = {1'b1, f[30:0]};
  endfunction : ord_key

  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? (32'h00000000 - v) : v;
  endfunction : abs32

  ////////////////////////////////////////////////////////////////////////////
  cbod_st_t st_reg;
  cbod_st_t st_next;

  logic [3:0]  f_r;
  logic [3:0]  f_s;
  logic [3:0]  f_t;
  logic [7:0]  f_op;
  logic        op0_ok;
  logic        fire;
  logic        any_nan;
  logic [31:0] key_s;
  logic [31:0] key_t;
  logic [32:0] trial;

  assign f_r    = INSTR[`CBOD_R_HI:`CBOD_R_LO];
  assign f_s    = INSTR[`CBOD_S_HI:`CBOD_S_LO];
  assign f_t    = INSTR[`CBOD_T_HI:`CBOD_T_LO];
  assign f_op   = INSTR[`CBOD_OP1_HI:`CBOD_OP2_LO];
  assign op0_ok = INSTR[`CBOD_OP0_HI:`CBOD_OP0_LO] == `CBOD_OP0_VAL;

  assign ISSUE_READY = (st_reg.state == CBOD_IDLE);
  assign fire        = ISSUE_VALID && ISSUE_READY && op0_ok;

  assign AR_RADDR_S = f_s;
  assign AR_RADDR_T = f_t;
  assign FR_RADDR_S = f_s;
  assign FR_RADDR_T = f_t;
  assign BR_RADDR_S = f_s;
  assign BR_RADDR_T = f_t;

  assign any_nan = is_nan(FR_RDATA_S) || is_nan(FR_RDATA_T);
  assign key_s   = ord_key(FR_RDATA_S);
  assign key_t   = ord_key(FR_RDATA_T);
  assign trial   = {st_reg.rem[31:0], st_reg.quo[31]} - {1'b0, st_reg.dvsr};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next          = st_reg;
    st_next.ar_we    = 1'b0;
    st_next.br_we    = 1'b0;
    st_next.exc_fp   = 1'b0;
    st_next.exc_div  = 1'b0;
    case (st_reg.state)
      CBOD_IDLE: begin
        if (fire) begin
          case (f_op)
            `CBOD_OP_OLE, `CBOD_OP_OLT: begin
              if (!FP_ENABLE) begin
                st_next.exc_fp = 1'b1;
              end else begin
                st_next.br_we    = 1'b1;
                st_next.br_waddr = f_r;
                if (f_op == `CBOD_OP_OLE)
                  st_next.br_wdata = !any_nan && (key_s <= key_t);
                else
                  st_next.br_wdata = !any_nan && (key_s < key_t);
              end
            end
            `CBOD_OP_OR: begin
              st_next.ar_we    = 1'b1;
              st_next.ar_waddr = f_r;
              st_next.ar_wdata = AR_RDATA_S | AR_RDATA_T;
            end
            `CBOD_OP_ORB: begin
              st_next.br_we    = 1'b1;
              st_next.br_waddr = f_r;
              st_next.br_wdata = BR_RDATA_S | BR_RDATA_T;
            end
            `CBOD_OP_BOOL_OR_COMPLEMENT_OP: begin
              st_next.br_we    = 1'b1;
              st_next.br_waddr = f_r;
              st_next.br_wdata = BR_RDATA_S | ~BR_RDATA_T;
            end
            `CBOD_OP_SIGNED_QUOTIENT_OP, `CBOD_OP_UNSIGNED_QUOTIENT_OP: begin
              if (AR_RDATA_T == 32'h00000000) begin
                st_next.exc_div = 1'b1;
              end else begin
                st_next.state = CBOD_DIV;
                st_next.dst   = f_r;
                st_next.rem   = 33'h000000000;
                st_next.cnt   = `CBOD_DIV_STEPS;
                if (f_op == `CBOD_OP_SIGNED_QUOTIENT_OP) begin
                  // magnitudes, sign fixed at the end; wraps for min/-1
                  st_next.quo   = abs32(AR_RDATA_S);
                  st_next.dvsr  = abs32(AR_RDATA_T);
                  st_next.neg_q = AR_RDATA_S[31] ^ AR_RDATA_T[31];
                end else begin
                  st_next.quo   = AR_RDATA_S;
                  st_next.dvsr  = AR_RDATA_T;
                  st_next.neg_q = 1'b0;
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      CBOD_DIV: begin
        // restoring division, one quotient bit per cycle
        if (!trial[32]) begin
          st_next.rem = trial;
          st_next.quo = {st_reg.quo[30:0], 1'b1};
        end else begin
          st_next.rem = {st_reg.rem[31:0], st_reg.quo[31]};
          st_next.quo = {st_reg.quo[30:0], 1'b0};
        end
        st_next.cnt = st_reg.cnt - 6'h01;
        if (st_reg.cnt == 6'h01)
          st_next.state = CBOD_DONE;
      end
      CBOD_DONE: begin
        st_next.ar_we    = 1'b1;
        st_next.ar_waddr = st_reg.dst;
        st_next.ar_wdata = st_reg.neg_q ? (32'h00000000 - st_reg.quo) : st_reg.quo;
        st_next.state    = CBOD_IDLE;
      end
      default: begin
        st_next.state = CBOD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST)
      st_reg <= '{state: CBOD_IDLE, default: '0};
    else
      st_reg <= st_next;
  end

  assign AR_WE                = st_reg.ar_we;
  assign AR_WADDR             = st_reg.ar_waddr;
  assign AR_WDATA             = st_reg.ar_wdata;
  assign BR_WE                = st_reg.br_we;
  assign BR_WADDR             = st_reg.br_waddr;
  assign BR_WDATA             = st_reg.br_wdata;
  assign FP_UNIT_DISABLED_EXC = st_reg.exc_fp;
  assign DIVIDE_BY_ZERO_EXC   = st_reg.exc_div;

endmodule : cbod_unit
`default_nettype wire

// ==== hdl/cbod_consts.svh ====
`ifndef CBOD_CONSTS_SVH
`define CBOD_CONSTS_SVH
// instruction word fields
`define CBOD_OP1_HI   23
`define CBOD_OP1_LO   20
`define CBOD_OP2_HI   19
`define CBOD_OP2_LO   16
`define CBOD_R_HI     15
`define CBOD_R_LO     12
`define CBOD_S_HI     11
`define CBOD_S_LO     8
`define CBOD_T_HI     7
`define CBOD_T_LO     4
`define CBOD_OP0_HI   3
`define CBOD_OP0_LO   0
// op1:op2 codes, op0 is zero for all
`define CBOD_OP0_VAL  4'h0
`define CBOD_OP_OLE   8'h6b
`define CBOD_OP_OLT   8'h4b
`define CBOD_OP_OR    8'h20
`define CBOD_OP_ORB   8'h22
`define CBOD_OP_BOOL_OR_COMPLEMENT_OP  8'h32
`define CBOD_OP_SIGNED_QUOTIENT_OP  8'hd2
`define CBOD_OP_UNSIGNED_QUOTIENT_OP  8'hc2
`define CBOD_DIV_STEPS 6'h20
`endif

// ==== hdl/cbod_pkg.sv ====
package cbod_pkg;
  typedef enum logic [2:0] {
    CBOD_IDLE = 3'b001,
    CBOD_DIV  = 3'b010,
    CBOD_DONE = 3'b100
  } cbod_state_t;

  typedef struct packed {
    cbod_state_t state;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [31:0] dvsr;
    logic [5:0]  cnt;
    logic        neg_q;
    logic [3:0]  dst;
    logic        ar_we;
    logic [3:0]  ar_waddr;
    logic [31:0] ar_wdata;
    logic        br_we;
    logic [3:0]  br_waddr;
    logic        br_wdata;
    logic        exc_fp;
    logic        exc_div;
  } cbod_st_t;
endpackage : cbod_pkg

// ==== bench/cbod_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cbod_consts.svh"
module cbod_checker (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        ISSUE_VALID,
  input wire logic [23:0] INSTR,
  input wire logic        FP_ENABLE,
  input wire logic        ISSUE_READY,
  input wire logic [31:0] AR_RDATA_S,
  input wire logic [31:0] AR_RDATA_T,
  input wire logic [31:0] FR_RDATA_S,
  input wire logic        BR_RDATA_S,
  input wire logic        BR_RDATA_T,
  input wire logic        AR_WE,
  input wire logic [3:0]  AR_WADDR,
  input wire logic [31:0] AR_WDATA,
  input wire logic        BR_WE,
  input wire logic        BR_WDATA,
  input wire logic        FP_UNIT_DISABLED_EXC,
  input wire logic        DIVIDE_BY_ZERO_EXC
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  wire       tk = ISSUE_VALID && ISSUE_READY && INSTR[3:0] == 4'h0;
  wire [7:0] op = INSTR[23:16];
  wire       cmp = tk && (op == `CBOD_OP_OLE || op == `CBOD_OP_OLT);
  wire       dv = tk && (op == `CBOD_OP_SIGNED_QUOTIENT_OP || op == `CBOD_OP_UNSIGNED_QUOTIENT_OP);
  sequence div_go; dv && AR_RDATA_T != 32'h0; endsequence
  sequence div_end; ##34 AR_WE && ISSUE_READY; endsequence
  AST_OR: assert property (tk && op == `CBOD_OP_OR |=>
    AR_WE && AR_WDATA == ($past(AR_RDATA_S) | $past(AR_RDATA_T))) else $error("or wrong");
  AST_ORB: assert property (tk && op == `CBOD_OP_ORB |=>
    BR_WE && BR_WDATA == ($past(BR_RDATA_S) | $past(BR_RDATA_T))) else $error("orb wrong");
  AST_BOOL_OR_COMPLEMENT_OP: assert property (tk && op == `CBOD_OP_BOOL_OR_COMPLEMENT_OP |=>
    BR_WE && BR_WDATA == ($past(BR_RDATA_S) | !$past(BR_RDATA_T))) else $error("bool_or_complement_op wrong");
  AST_FPOFF: assert property (cmp && !FP_ENABLE |=>
    FP_UNIT_DISABLED_EXC && !BR_WE) else $error("fp off not trapped");
  AST_NAN: assert property (cmp && FP_ENABLE && &FR_RDATA_S[30:23] && |FR_RDATA_S[22:0]
    |=> BR_WE && !BR_WDATA) else $error("nan compare not zero");
  AST_DZ: assert property (dv && AR_RDATA_T == 32'h0 |=>
    DIVIDE_BY_ZERO_EXC && !AR_WE) else $error("zero divisor not trapped");
  AST_STALL: assert property (div_go |=> !ISSUE_READY [*8]) else $error("no stall");
  AST_DONE: assert property (div_go |-> div_end) else $error("quotient late");
  AST_WADDR: assert property (div_go |-> ##34 AR_WADDR == $past(INSTR[15:12], 34))
    else $error("quotient destination wrong");
endmodule : cbod_checker
bind cbod_unit cbod_checker u_chk (.*);
`default_nettype wire

// ==== bench/cbod_rf_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbod_rf_model (
  input  wire logic [3:0]  AR_RADDR_S,
  input  wire logic [3:0]  AR_RADDR_T,
  input  wire logic [3:0]  FR_RADDR_S,
  input  wire logic [3:0]  FR_RADDR_T,
  input  wire logic [3:0]  BR_RADDR_S,
  input  wire logic [3:0]  BR_RADDR_T,
  output logic      [31:0] AR_RDATA_S,
  output logic      [31:0] AR_RDATA_T,
  output logic      [31:0] FR_RDATA_S,
  output logic      [31:0] FR_RDATA_T,
  output logic             BR_RDATA_S,
  output logic             BR_RDATA_T
);
  logic [31:0] ar [16];
  logic [31:0] fr [16];
  logic [15:0] br;
  // same-cycle read ports, loaded by the bench
  assign AR_RDATA_S = ar[AR_RADDR_S];
  assign AR_RDATA_T = ar[AR_RADDR_T];
  assign FR_RDATA_S = fr[FR_RADDR_S];
  assign FR_RDATA_T = fr[FR_RADDR_T];
  assign BR_RDATA_S = br[BR_RADDR_S];
  assign BR_RDATA_T = br[BR_RADDR_T];
endmodule : cbod_rf_model
`default_nettype wire

// ==== bench/tb_cmp_bool_or_divide_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cbod_consts.svh"
module tb_cmp_bool_or_divide_unit;
  logic        CLOCK = 1'b0;
  logic        SRST = 1'b1;
  logic        ISSUE_VALID = 1'b0;
  logic        FP_ENABLE = 1'b1;
  logic [23:0] INSTR = 24'h0;
  logic        ISSUE_READY, AR_WE, BR_WE, BR_WDATA, BR_RDATA_S, BR_RDATA_T;
  logic        FP_UNIT_DISABLED_EXC, DIVIDE_BY_ZERO_EXC;
  logic [3:0]  AR_RADDR_S, AR_RADDR_T, FR_RADDR_S, FR_RADDR_T, BR_RADDR_S, BR_RADDR_T;
  logic [3:0]  AR_WADDR, BR_WADDR;
  logic [31:0] AR_RDATA_S, AR_RDATA_T, FR_RDATA_S, FR_RDATA_T, AR_WDATA;
  int          fail_count = 0, compares = 0, cyc = 0;
  cbod_unit u_dut (.*);
  cbod_rf_model u_rf (.*);
  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  task chk(input logic [39:0] s, input logic [39:0] e, input string n);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // offers one word; returns just after the take edge
  task go(input logic [7:0] op, input logic [11:0] rst);
    INSTR = {op, rst, 4'h0};
    ISSUE_VALID = 1'b1;
    @(posedge CLOCK);
    #1;
  endtask : go
  task t_logic;
    u_rf.ar[2] = 32'hf0f0_0001;
    u_rf.ar[3] = 32'h0f00_8000;
    go(`CBOD_OP_OR, 12'h123);
    chk({AR_WE, AR_WADDR, AR_WDATA}, {5'h11, 32'hfff0_8001}, "or");
    for (int i = 0; i < 4; i++) begin
      u_rf.br[2:1] = i[1:0];
      go(`CBOD_OP_ORB, 12'h512);
      chk({BR_WE, BR_WADDR, BR_WDATA}, {5'h15, i[0] | i[1]}, "orb");
      go(`CBOD_OP_BOOL_OR_COMPLEMENT_OP, 12'h612);
      chk({BR_WE, BR_WADDR, BR_WDATA}, {5'h16, i[0] | !i[1]}, "bool_or_complement_op");
    end
  endtask : t_logic
  task t_cmp;
    logic [31:0] a [8] = '{32'h3f80_0000, 32'h4000_0000, 32'h0, 32'h8000_0000,
                           32'h3f80_0000, 32'h7fc0_0000, 32'hc000_0000, 32'h3f80_0000};
    logic [31:0] b [8] = '{32'h4000_0000, 32'h3f80_0000, 32'h8000_0000, 32'h0,
                           32'h3f80_0000, 32'h3f80_0000, 32'hbf80_0000, 32'h7f80_0001};
    logic [1:0]  e [8] = '{2'h3, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h3, 2'h0};
    for (int i = 0; i < 8; i++) begin
      u_rf.fr[4] = a[i];
      u_rf.fr[5] = b[i];
      go(`CBOD_OP_OLE, 12'h745);
      chk({BR_WE, BR_WDATA}, {1'b1, e[i][1]}, "ole");
      go(`CBOD_OP_OLT, 12'h745);
      chk({BR_WE, BR_WDATA}, {1'b1, e[i][0]}, "olt");
    end
    FP_ENABLE = 1'b0;
    go(`CBOD_OP_OLT, 12'h745);
    chk({FP_UNIT_DISABLED_EXC, BR_WE}, 2'b10, "fp off");
    FP_ENABLE = 1'b1;
  endtask : t_cmp
  task t_div(input logic [7:0] op, input logic [31:0] a, b, q);
    u_rf.ar[2] = a;
    u_rf.ar[3] = b;
    go(op, 12'h923);
    ISSUE_VALID = 1'b0;
    if (b === 32'h0) begin
      chk({DIVIDE_BY_ZERO_EXC, AR_WE, ISSUE_READY}, 3'b101, "div zero");
    end else begin
      repeat (32) @(posedge CLOCK);
      #1;
      chk(ISSUE_READY, 1'b0, "stall");
      @(posedge CLOCK);
      #1;
      chk({AR_WE, ISSUE_READY, AR_WADDR, AR_WDATA}, {6'h39, q}, "quo");
    end
    @(posedge CLOCK);
    #1;
  endtask : t_div
  task final_report;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge CLOCK);
    #1;
    SRST = 1'b0;
    t_logic;
    t_cmp;
    t_div(`CBOD_OP_SIGNED_QUOTIENT_OP, 32'h7, 32'hffff_fffe, 32'hffff_fffd);
    t_div(`CBOD_OP_SIGNED_QUOTIENT_OP, 32'hffff_fff9, 32'h2, 32'hffff_fffd);
    t_div(`CBOD_OP_SIGNED_QUOTIENT_OP, 32'h8000_0000, 32'hffff_ffff, 32'h8000_0000);
    t_div(`CBOD_OP_UNSIGNED_QUOTIENT_OP, 32'hffff_ffff, 32'h2, 32'h7fff_ffff);
    t_div(`CBOD_OP_SIGNED_QUOTIENT_OP, 32'h5, 32'h0, 32'h0);
    t_div(`CBOD_OP_UNSIGNED_QUOTIENT_OP, 32'h5, 32'h0, 32'h0);
    final_report;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      final_report;
    end
  end
endmodule : tb_cmp_bool_or_divide_unit
`default_nettype wire
